// File: hdl/serdes_phy_config_pkg.sv
`default_nettype none

package serdes_phy_config_pkg;

    typedef enum logic [1:0] {
        DIV_NONE,
        DIV_BY2,
        DIV_BY4
    } oversample_div_e;

    typedef struct packed {
        logic [4:0] lane_phy_powerdown_bits;
        logic sync_buffer_powerdown;
        logic recovery_logic_run;
        logic half_rate_enable;
        oversample_div_e oversample_div;
        logic [3:0] lane1_equalizer_setting;
        logic [3:0] lane0_equalizer_setting;
        logic [1:0] eq_manual;
    } phy_cfg_s;

endpackage

`default_nettype wire

// File: hdl/serdes_phy_config_regs.sv
// Summary of operation
// R1 - bits 3..7 of lane PHY power-down register each power down one lane
// R2 - misc power-down bit 1 powers down the sync request buffer; resets 0
// R3 - recovery reset bit 0 low holds PHY control logic in reset; resets 1
// R4 - rate mode bit 5 selects half-rate recovery above 6 Gbps; resets 1
// R5 - rate mode bits 2:1 code 10 divides oversampling by four
// R6 - software picks no division above 3 Gbps, by two up to 3 Gbps
// R7 - divider code 00 none, 01 by two; reserved code 11 is not stored
// R8 - per-lane equalizer nibble: 0000 manual, else boost level; resets 0x8
`timescale 1ns/1ps
`default_nettype none
`include "serdes_phy_config_regs.svh"

module serdes_phy_config_regs (
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // serial configuration port
    input wire logic spi_csb_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_sdi_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out,
    // configuration to the lane front end
    output var serdes_phy_config_pkg::phy_cfg_s phy_cfg_out
);

    typedef enum logic {ST_INSTR, ST_DATA} frame_state_e;

    // synchronisers: stage 1 read only by stage 2
    logic [1:0] csb_sync_r;
    logic [2:0] sclk_sync_r;
    logic [1:0] sdi_sync_r;
    logic sclk_rise;
    logic frame_active;

    frame_state_e state_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_in_r;
    logic read_r;
    logic [14:0] addr_r;
    logic [7:0] shift_out_r;
    logic wr_stb_r;
    logic [7:0] wr_data_r;
    logic [14:0] wr_addr_r;

    logic [4:0] lane_pd_r;
    logic [1:0] misc_pd_r;
    logic recovery_run_r;
    logic [7:0] rate_mode_r;
    logic [7:0] eq_r;
    logic [7:0] rd_data;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            csb_sync_r <= 2'h3;
            sclk_sync_r <= 3'h0;
            sdi_sync_r <= 2'h0;
        end else if (ce_in) begin
            csb_sync_r <= {csb_sync_r[0], spi_csb_n_in};
            sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk_in};
            sdi_sync_r <= {sdi_sync_r[0], spi_sdi_in};
        end
    end

    // edges are judged on stages 2 and 3 only
    assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
    assign frame_active = ~csb_sync_r[1];

    // frame decoder: 16 instruction bits (rw, 15-bit address), 8 data bits
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ST_INSTR;
            bit_cnt_r <= 5'h00;
            shift_in_r <= 16'h0000;
            read_r <= 1'b0;
            addr_r <= 15'h0000;
        end else if (ce_in) begin
            if (!frame_active) begin
                state_r <= ST_INSTR;
                bit_cnt_r <= 5'h00;
            end else if (sclk_rise) begin
                shift_in_r <= {shift_in_r[14:0], sdi_sync_r[1]};
                bit_cnt_r <= bit_cnt_r + 5'h01;
                unique case (state_r)
                    ST_INSTR: begin
                        if (bit_cnt_r == `SPI_INSTR_BITS - 5'h01) begin
                            state_r <= ST_DATA;
                            read_r <= shift_in_r[14];
                            addr_r <= {shift_in_r[13:0], sdi_sync_r[1]};
                        end
                    end
                    ST_DATA: begin
                        // count saturates past the last data bit so that
                        // extra clocks cannot raise a second write strobe
                        if (bit_cnt_r == `SPI_FRAME_BITS) begin
                            bit_cnt_r <= bit_cnt_r;
                        end
                    end
                endcase
            end
        end
    end

    // write strobe after the last data bit
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_stb_r <= 1'b0;
            wr_data_r <= 8'h00;
            wr_addr_r <= 15'h0000;
        end else if (ce_in) begin
            wr_stb_r <= frame_active && sclk_rise && state_r == ST_DATA
                && !read_r && bit_cnt_r == `SPI_FRAME_BITS - 5'h01;
            wr_data_r <= {shift_in_r[6:0], sdi_sync_r[1]};
            wr_addr_r <= addr_r;
        end
    end

    always_comb begin
        rd_data = 8'h00;
        unique case (addr_r)
            `ADDR_LANE_PHY_POWERDOWN: rd_data = {lane_pd_r, 3'h0};
            `ADDR_MISC_POWERDOWN: rd_data = {6'h00, misc_pd_r};
            `ADDR_RECOVERY_LOGIC_RESET: rd_data = {7'h00, recovery_run_r};
            `ADDR_RECOVERY_RATE_MODE: rd_data = rate_mode_r;
            `ADDR_LANE0_1_EQUALIZER: rd_data = eq_r;
            default: rd_data = 8'h00;
        endcase
    end

    // read data shifts out msb first, one bit per rising sclk
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_out_r <= 8'h00;
            spi_sdo_oe_out <= 1'b0;
        end else if (ce_in) begin
            if (!frame_active) begin
                spi_sdo_oe_out <= 1'b0;
            end else if (sclk_rise && state_r == ST_INSTR
                         && bit_cnt_r == `SPI_INSTR_BITS - 5'h01) begin
                spi_sdo_oe_out <= shift_in_r[14];
            end else if (state_r == ST_DATA && read_r && !sclk_rise
                         && bit_cnt_r == `SPI_INSTR_BITS) begin
                shift_out_r <= rd_data;
            end else if (sclk_rise && state_r == ST_DATA) begin
                shift_out_r <= {shift_out_r[6:0], 1'b0};
            end
        end
    end
    assign spi_sdo_out = shift_out_r[7];

    // register writes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lane_pd_r <= 5'h00;
            misc_pd_r <= 2'h0;
            recovery_run_r <= 1'b1;
            rate_mode_r <= `RST_RECOVERY_RATE_MODE;
            eq_r <= `RST_LANE0_1_EQUALIZER;
        end else if (ce_in && wr_stb_r) begin
            unique case (wr_addr_r)
                `ADDR_LANE_PHY_POWERDOWN:
                    lane_pd_r <= wr_data_r[`POS_LANE_PD_HI:`POS_LANE_PD_LO]; // R1
                `ADDR_MISC_POWERDOWN:
                    misc_pd_r <= wr_data_r[1:0]; // R2
                `ADDR_RECOVERY_LOGIC_RESET:
                    recovery_run_r <= wr_data_r[`POS_RECOVERY_RUN]; // R3
                `ADDR_RECOVERY_RATE_MODE: begin
                    rate_mode_r[7:3] <= wr_data_r[7:3]; // R4
                    rate_mode_r[0] <= wr_data_r[0];
                    // a reserved divider code would leave the lanes unclocked
                    if (wr_data_r[`POS_DIV_HI:`POS_DIV_LO] != `DIV_CODE_RSVD) begin
                        rate_mode_r[2:1] <= wr_data_r[2:1]; // R7
                    end
                end
                `ADDR_LANE0_1_EQUALIZER:
                    eq_r <= wr_data_r; // R8
                default: begin
                end
            endcase
        end
    end

    // configuration outputs, one power-down per lane
    genvar k;
    generate
        for (k = 0; k < 5; k++) begin : g_lane_pd
            assign phy_cfg_out.lane_phy_powerdown_bits[k] = lane_pd_r[k]; // R1
        end
        for (k = 0; k < 2; k++) begin : g_eq_manual
            assign phy_cfg_out.eq_manual[k] = eq_r[4*k +: 4] == 4'h0; // R8
        end
    endgenerate

    assign phy_cfg_out.sync_buffer_powerdown = misc_pd_r[`POS_SYNC_BUF_PD]; // R2
    assign phy_cfg_out.recovery_logic_run = recovery_run_r; // R3
    assign phy_cfg_out.half_rate_enable = rate_mode_r[`POS_HALF_RATE]; // R4
    assign phy_cfg_out.oversample_div =
        serdes_phy_config_pkg::oversample_div_e'(rate_mode_r[2:1]); // R5
    assign phy_cfg_out.lane1_equalizer_setting = eq_r[`POS_EQ1_HI:`POS_EQ1_LO];
    assign phy_cfg_out.lane0_equalizer_setting = eq_r[`POS_EQ0_HI:`POS_EQ0_LO];

    property p_lane_pd;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && wr_stb_r && wr_addr_r == `ADDR_LANE_PHY_POWERDOWN
        |=> phy_cfg_out.lane_phy_powerdown_bits == $past(wr_data_r[7:3]);
    endproperty
    a_lane_pd: assert property (p_lane_pd) // R1
        else $error("lane power-down bits did not follow write");

    property p_sync_pd;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && wr_stb_r && wr_addr_r == `ADDR_MISC_POWERDOWN
        |=> phy_cfg_out.sync_buffer_powerdown == $past(wr_data_r[1]);
    endproperty
    a_sync_pd: assert property (p_sync_pd) // R2
        else $error("sync buffer power-down did not follow bit 1");

    property p_recovery_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !(ce_in && wr_stb_r && wr_addr_r == `ADDR_RECOVERY_LOGIC_RESET)
        |=> $stable(phy_cfg_out.recovery_logic_run);
    endproperty
    a_recovery_hold: assert property (p_recovery_hold) // R3
        else $error("recovery reset changed without a write");

    property p_half_rate;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && wr_stb_r && wr_addr_r == `ADDR_RECOVERY_RATE_MODE
        |=> phy_cfg_out.half_rate_enable == $past(wr_data_r[5]);
    endproperty
    a_half_rate: assert property (p_half_rate) // R4
        else $error("half rate enable did not follow bit 5");

    property p_div4;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && wr_stb_r && wr_addr_r == `ADDR_RECOVERY_RATE_MODE
        && wr_data_r[2:1] == `DIV_CODE_BY4
        |=> phy_cfg_out.oversample_div == serdes_phy_config_pkg::DIV_BY4;
    endproperty
    a_div4: assert property (p_div4) // R5
        else $error("code 10 did not select divide by four");

    property p_div_rsvd;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && wr_stb_r && wr_data_r[2:1] == `DIV_CODE_RSVD
        |=> $stable(phy_cfg_out.oversample_div);
    endproperty
    a_div_rsvd: assert property (p_div_rsvd) // R7
        else $error("reserved divider code was stored");

    property p_eq;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ce_in && wr_stb_r && wr_addr_r == `ADDR_LANE0_1_EQUALIZER
        |=> phy_cfg_out.lane0_equalizer_setting == $past(wr_data_r[3:0])
            && phy_cfg_out.eq_manual[1] == ($past(wr_data_r[7:4]) == 4'h0);
    endproperty
    a_eq: assert property (p_eq) // R8
        else $error("equalizer settings did not follow write");

endmodule // serdes_phy_config_regs
`default_nettype wire

// File: hdl/serdes_phy_config_regs.svh
`ifndef SERDES_PHY_CONFIG_REGS_SVH
`define SERDES_PHY_CONFIG_REGS_SVH

// register offsets on the serial configuration port
`define ADDR_LANE_PHY_POWERDOWN 15'h0201
`define ADDR_MISC_POWERDOWN 15'h0203
`define ADDR_RECOVERY_LOGIC_RESET 15'h0206
`define ADDR_RECOVERY_RATE_MODE 15'h0230
`define ADDR_LANE0_1_EQUALIZER 15'h0250

// reset values
`define RST_LANE_PHY_POWERDOWN 8'h00
`define RST_MISC_POWERDOWN 8'h00
`define RST_RECOVERY_LOGIC_RESET 8'h01
`define RST_RECOVERY_RATE_MODE 8'h60
`define RST_LANE0_1_EQUALIZER 8'h88

// field positions
`define POS_LANE_PD_LO 3
`define POS_LANE_PD_HI 7
`define POS_SYNC_BUF_PD 1
`define POS_RECOVERY_RUN 0
`define POS_HALF_RATE 5
`define POS_DIV_LO 1
`define POS_DIV_HI 2
`define POS_EQ0_LO 0
`define POS_EQ0_HI 3
`define POS_EQ1_LO 4
`define POS_EQ1_HI 7

// oversampling divider codes
`define DIV_CODE_NONE 2'h0
`define DIV_CODE_BY2 2'h1
`define DIV_CODE_BY4 2'h2
`define DIV_CODE_RSVD 2'h3

// serial frame: instruction bits, then data bits
`define SPI_INSTR_BITS 5'h10
`define SPI_FRAME_BITS 5'h18

`endif

// File: sim/test_serdes_phy_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "serdes_phy_config_regs.svh"

module test_serdes_phy_config_regs;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic spi_csb_n_in = 1'b1;
    logic spi_sclk_in = 1'b0;
    logic spi_sdi_in = 1'b0;
    logic spi_sdo_out;
    logic spi_sdo_oe_out;
    serdes_phy_config_pkg::phy_cfg_s cfg;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] rd_v;
    logic oe_v;
    logic [7:0] eqs [4] = '{8'h00, 8'h0F, 8'hF1, 8'h35};

    serdes_phy_config_regs dut (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .spi_csb_n_in(spi_csb_n_in),
        .spi_sclk_in(spi_sclk_in),
        .spi_sdi_in(spi_sdi_in),
        .spi_sdo_out(spi_sdo_out),
        .spi_sdo_oe_out(spi_sdo_oe_out),
        .phy_cfg_out(cfg)
    );

    initial begin
        forever #20 mclk_in = ~mclk_in;
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // sclk phases of 4 mclk leave margin over the 3-cycle synchroniser need;
    // sdo is sampled on the falling mclk just before each data-bit sclk rise
    task automatic frame(input logic rd, input logic [14:0] addr,
        input logic [7:0] wd, input int nbits);
        logic [23:0] f;
        f = {rd, addr, wd};
        @(posedge mclk_in) spi_csb_n_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        for (int i = 0; i < nbits; i++) begin
            spi_sdi_in <= (i < 24) ? f[23 - i] : 1'b1;
            spi_sclk_in <= 1'b0;
            repeat (4) @(negedge mclk_in);
            if (i >= 16) rd_v = {rd_v[6:0], spi_sdo_out};
            if (i == 16) oe_v = spi_sdo_oe_out;
            @(posedge mclk_in) spi_sclk_in <= 1'b1;
            repeat (4) @(posedge mclk_in);
        end
        spi_sclk_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        spi_csb_n_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
    endtask

    task automatic wr(input logic [14:0] addr, input logic [7:0] d);
        frame(1'b0, addr, d, 24);
        check("sdo oe in write", 8'(oe_v), 8'h00);
    endtask

    task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
        frame(1'b1, addr, 8'h00, 24);
        check($sformatf("read %h", addr), rd_v, exp);
        check("sdo oe in read", 8'(oe_v), 8'h01);
        check("sdo oe idle", 8'(spi_sdo_oe_out), 8'h00);
    endtask

    initial begin
        logic [7:0] m;
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(negedge mclk_in);
        check("lane pd", 8'(cfg.lane_phy_powerdown_bits), 8'h00);
        check("sync pd", 8'(cfg.sync_buffer_powerdown), 8'h00);
        check("run", 8'(cfg.recovery_logic_run), 8'h01);
        check("half rate", 8'(cfg.half_rate_enable), 8'h01);
        check("divider", 8'(cfg.oversample_div), 8'h00);
        check("eq", {cfg.lane1_equalizer_setting,
            cfg.lane0_equalizer_setting}, 8'h88);
        rd_chk(`ADDR_LANE_PHY_POWERDOWN, 8'h00);
        rd_chk(`ADDR_MISC_POWERDOWN, 8'h00);
        rd_chk(`ADDR_RECOVERY_LOGIC_RESET, 8'h01);
        rd_chk(`ADDR_RECOVERY_RATE_MODE, 8'h60);
        rd_chk(`ADDR_LANE0_1_EQUALIZER, 8'h88);
        wr(`ADDR_LANE_PHY_POWERDOWN, 8'hFF);
        check("lane pd", 8'(cfg.lane_phy_powerdown_bits), 8'h1F);
        rd_chk(`ADDR_LANE_PHY_POWERDOWN, 8'hF8);
        wr(`ADDR_LANE_PHY_POWERDOWN, 8'hA8);
        check("lane pd", 8'(cfg.lane_phy_powerdown_bits), 8'h15);
        wr(`ADDR_MISC_POWERDOWN, 8'h02);
        check("sync pd", 8'(cfg.sync_buffer_powerdown), 8'h01);
        rd_chk(`ADDR_MISC_POWERDOWN, 8'h02);
        wr(`ADDR_MISC_POWERDOWN, 8'hFD);
        check("sync pd", 8'(cfg.sync_buffer_powerdown), 8'h00);
        rd_chk(`ADDR_MISC_POWERDOWN, 8'h01);
        wr(`ADDR_RECOVERY_LOGIC_RESET, 8'hFE);
        check("run", 8'(cfg.recovery_logic_run), 8'h00);
        rd_chk(`ADDR_RECOVERY_LOGIC_RESET, 8'h00);
        wr(`ADDR_RECOVERY_LOGIC_RESET, 8'h01);
        check("run", 8'(cfg.recovery_logic_run), 8'h01);
        for (int c = 0; c < 3; c++) begin
            m = {2'b01, c[0], 2'b00, c[1:0], 1'b0};
            wr(`ADDR_RECOVERY_RATE_MODE, m);
            check("half rate", 8'(cfg.half_rate_enable), 8'(c[0]));
            check("divider", 8'(cfg.oversample_div), 8'(c));
            rd_chk(`ADDR_RECOVERY_RATE_MODE, m);
        end
        // reserved divider code keeps the by-four setting from the loop
        wr(`ADDR_RECOVERY_RATE_MODE, 8'h66);
        check("divider", 8'(cfg.oversample_div), 8'h02);
        rd_chk(`ADDR_RECOVERY_RATE_MODE, 8'h64);
        foreach (eqs[k]) begin
            wr(`ADDR_LANE0_1_EQUALIZER, eqs[k]);
            check("eq", {cfg.lane1_equalizer_setting,
                cfg.lane0_equalizer_setting}, eqs[k]);
            check("manual", 8'(cfg.eq_manual), {6'h00,
                eqs[k][7:4] == 4'h0, eqs[k][3:0] == 4'h0});
            rd_chk(`ADDR_LANE0_1_EQUALIZER, eqs[k]);
        end
        wr(`ADDR_LANE0_1_EQUALIZER + 15'h1, 8'h55);
        rd_chk(`ADDR_LANE0_1_EQUALIZER + 15'h1, 8'h00);
        rd_chk(`ADDR_LANE0_1_EQUALIZER, 8'h35);
        // short frame must not write
        frame(1'b0, `ADDR_LANE0_1_EQUALIZER, 8'hC4, 20);
        rd_chk(`ADDR_LANE0_1_EQUALIZER, 8'h35);
        // clocks past the last data bit must not write again
        frame(1'b0, `ADDR_LANE0_1_EQUALIZER, 8'h3C, 26);
        rd_chk(`ADDR_LANE0_1_EQUALIZER, 8'h3C);
        // frozen by the clock enable, a whole write frame goes unseen
        ce_in <= 1'b0;
        wr(`ADDR_LANE0_1_EQUALIZER, 8'h5A);
        ce_in <= 1'b1;
        rd_chk(`ADDR_LANE0_1_EQUALIZER, 8'h3C);
        wr(`ADDR_RECOVERY_LOGIC_RESET, 8'h00);
        wr(`ADDR_RECOVERY_RATE_MODE, 8'h40);
        @(posedge mclk_in) rst_n_in <= 1'b0;
        repeat (2) @(negedge mclk_in);
        check("run", 8'(cfg.recovery_logic_run), 8'h01);
        check("half rate", 8'(cfg.half_rate_enable), 8'h01);
        check("eq", {cfg.lane1_equalizer_setting,
            cfg.lane0_equalizer_setting}, 8'h88);
        @(posedge mclk_in) rst_n_in <= 1'b1;
        rd_chk(`ADDR_RECOVERY_RATE_MODE, 8'h60);
        conclude();
    end

    // about 40 frames of some 210 cycles each are expected
    initial begin
        repeat (30000) @(posedge mclk_in);
        err_count++;
        conclude();
    end
endmodule // test_serdes_phy_config_regs
`default_nettype wire
